// ---- ssp_pkg.sv ----
// ssp_pkg.sv: constants and types of the synchronous serial port.
// assumes: one 200 MHz clock, configuration bits on plain ports.
package ssp_pkg;
  localparam int SSP_WIDTH = 16; // fifo word width
  localparam int SSP_DEPTH = 8; // fifo entries
  localparam logic [3:0] SSP_FULL = 4'h8; // fifo count when full
  localparam logic [3:0] SSP_TX_SERVICE = 4'h4; // tx service at or below
  localparam logic [3:0] SSP_RX_SERVICE = 4'h4; // rx service at or above
  localparam logic [4:0] SSP_MIN_BITS = 5'h04; // shortest frame
  localparam logic [4:0] SSP_PULSE_SKIP = 5'h01; // frame pulse slot
  localparam logic [4:0] SSP_CMD_SKIP = 5'h09; // control byte + wait
  localparam logic [6:0] SSP_TIMEOUT_HALF = 7'h40; // 32 idle periods
  localparam logic [5:0] SSP_TAIL_HALF = 6'h02; // frame hold after end
  localparam int SSP_IRQ_TX = 0; // status bit positions
  localparam int SSP_IRQ_RX = 1;
  localparam int SSP_IRQ_TMO = 2;
  localparam int SSP_IRQ_OVR = 3;
  localparam logic [1:0] SSP_FMT_SPI = 2'h0; // format select codes
  localparam logic [1:0] SSP_FMT_PULSE = 2'h1;
  localparam logic [1:0] SSP_FMT_CMD = 2'h2;
  typedef enum logic [1:0] {SSP_IDLE, SSP_START, SSP_XFER, SSP_TAIL}
    ssp_state_t;
endpackage

// ---- ssp_fifo_if.sv ----
// ssp_fifo_if.sv: push/pop port between the port core and a fifo.
// assumes: all signals on the single system clock.
`timescale 1ns/1ps
interface ssp_fifo_if;
  logic push; // write one word
  logic [15:0] push_data; // word to write
  logic pop; // drop oldest word
  logic [15:0] head; // oldest word
  logic [3:0] count; // words held
  modport owner (input push, push_data, pop, output head, count);
  modport user (output push, push_data, pop, input head, count);
endinterface

// ---- ssp_fifo.sv ----
// ssp_fifo.sv: 16-bit by 8-entry first-in first-out buffer.
// assumes: user never pushes when full nor pops when empty.
`timescale 1ns/1ps
module ssp_fifo import ssp_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  ssp_fifo_if.owner port_if
);
  typedef struct packed {
    logic [SSP_DEPTH-1:0][SSP_WIDTH-1:0] mem; // storage
    logic [2:0] wp; // write pointer
    logic [2:0] rp; // read pointer
    logic [3:0] cnt; // fill level
  } ssp_fifo_regs_t;
  ssp_fifo_regs_t r;
  ssp_fifo_regs_t next_r;
  logic do_push; // guarded push
  logic do_pop; // guarded pop

  // pointer and level update
  always_comb begin
    next_r = r;
    do_push = port_if.push && (r.cnt != SSP_FULL);
    do_pop = port_if.pop && (r.cnt != 4'h0);
    if (do_push) begin
      next_r.mem[r.wp] = port_if.push_data;
      next_r.wp = r.wp + 3'h1;
    end
    if (do_pop) begin
      next_r.rp = r.rp + 3'h1;
    end
    next_r.cnt = r.cnt + {3'h0, do_push} - {3'h0, do_pop};
  end

  // state register
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign port_if.head = r.mem[r.rp];
  assign port_if.count = r.cnt;

  fifo_bound_a: assert property (@(posedge ref_clk_in) disable iff
    (sys_rst_in) r.cnt <= SSP_FULL) else $error("fifo over 8");
  fifo_order_a: assert property (@(posedge ref_clk_in) disable iff
    (sys_rst_in) do_push && !do_pop && r.cnt == 4'h0 |=>
    port_if.head == $past(port_if.push_data))
    else $error("fifo head not first word");
endmodule

// ---- ssp_top.sv ----
// ssp_top.sv: synchronous serial port core, master or slave.
// assumes: pins asynchronous, configuration steady during frames.
`timescale 1ns/1ps
module ssp_top import ssp_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic enable_in,
  input wire logic master_in,
  input wire logic [1:0] format_in,
  input wire logic clock_polarity_in,
  input wire logic clock_phase_in,
  input wire logic loopback_in,
  input wire logic [3:0] data_size_in,
  input wire logic [7:0] clock_prescale_divisor_in,
  input wire logic [7:0] serial_clock_rate_in,
  input wire logic [3:0] interrupt_mask_in,
  input wire logic overrun_clear_in,
  input wire logic tx_wr_in,
  input wire logic [15:0] tx_data_in,
  output logic tx_ready_out,
  input wire logic rx_rd_in,
  output logic [15:0] rx_data_out,
  output logic rx_valid_out,
  output logic [3:0] raw_interrupt_status_out,
  output logic [3:0] masked_interrupt_status_out,
  output logic irq_out,
  output logic busy_out,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_n_out,
  input wire logic frame_select_pin_in,
  output logic frame_select_pin_out,
  output logic frame_select_pin_oe_n_out,
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe_n_out,
  input wire logic serial_in_pin_in
);
  typedef struct packed {
    ssp_state_t st; // frame sequencer
    logic [6:0] pre_cnt; // prescale half counter
    logic [7:0] rate_cnt; // rate counter
    logic [5:0] edge_cnt; // clock edges in frame
    logic [4:0] slots; // bit slots of frame
    logic [4:0] skip; // leading slots not captured
    logic [1:0] fmt; // format of frame
    logic capf; // capture on first edge
    logic [24:0] tx_sh; // transmit shifter
    logic [15:0] rx_sh; // receive shifter
    logic sclk; // serial clock out
    logic fss; // frame out
    logic sout; // serial data out
    logic sout_oe_n; // data out enable
    logic drv_oe_n; // clock/frame enable
    logic [2:0] sclk_s; // clock synchroniser
    logic [2:0] fss_s; // frame synchroniser
    logic [1:0] sin_s; // data synchroniser
    logic [15:0] rx_data; // word shown to user
    logic rx_valid; // rx_data holds a word
    logic tx_ready; // tx fifo has room
    logic ovr; // sticky overrun
    logic [6:0] idle_cnt; // idle half periods
    logic [3:0] raw; // raw status
    logic [3:0] mis; // masked status
    logic irq; // combined request
    logic busy; // frame in progress
  } ssp_regs_t;
  ssp_regs_t r;
  ssp_regs_t next_r;

  ssp_fifo_if tx_if ();
  ssp_fifo_if rx_if ();
  logic [6:0] psc_half; // prescale divisor over two
  logic pre_wrap; // prescaler end
  logic half_tick; // serial half period enable
  logic [4:0] nbits; // data bits of frame
  logic idle_now; // clock idle level
  logic in_bit; // serial input bit
  logic s_edge; // slave clock changed
  logic start; // frame load
  logic ev; // clock edge in frame
  logic cap; // this edge captures
  logic fin; // last edge of frame

  // left aligned shift pattern per format
  function automatic logic [24:0] load_shift(input logic [1:0] fmt,
    input logic [4:0] n, input logic [15:0] d);
    logic [15:0] al;
    al = d << (5'h10 - n);
    if (fmt == SSP_FMT_PULSE) begin
      load_shift = {1'b0, al, 8'h00};
    end else if (fmt == SSP_FMT_CMD) begin
      load_shift = {d[7:0], 17'h00000};
    end else begin
      load_shift = {al, 9'h000};
    end
  endfunction

  ssp_fifo u_tx_fifo (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .port_if(tx_if.owner));
  ssp_fifo u_rx_fifo (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .port_if(rx_if.owner));

  // divider terms, even values only
  assign psc_half = (clock_prescale_divisor_in[7:1] == 7'h00) ? 7'h01 :
    clock_prescale_divisor_in[7:1];
  assign pre_wrap = r.pre_cnt >= psc_half - 7'h01;
  assign half_tick = pre_wrap && (r.rate_cnt >= serial_clock_rate_in);
  assign nbits = ({1'b0, data_size_in} < SSP_MIN_BITS - 5'h01) ?
    SSP_MIN_BITS : {1'b0, data_size_in} + 5'h01;
  assign idle_now = (format_in == SSP_FMT_SPI) && clock_polarity_in;
  assign in_bit = loopback_in ? r.sout : r.sin_s[1];
  assign s_edge = r.sclk_s[1] != r.sclk_s[2];

  // next state of the whole port
  always_comb begin
    next_r = r;
    start = 1'b0;
    ev = 1'b0;
    cap = 1'b0;
    fin = 1'b0;
    tx_if.push = tx_wr_in && r.tx_ready;
    tx_if.push_data = tx_data_in;
    tx_if.pop = 1'b0;
    rx_if.pop = r.rx_valid && rx_rd_in;
    rx_if.push = 1'b0;
    // pins pass two flops, third only for edges
    next_r.sclk_s = {r.sclk_s[1:0], serial_clock_pin_in};
    next_r.fss_s = {r.fss_s[1:0], frame_select_pin_in};
    next_r.sin_s = {r.sin_s[0], serial_in_pin_in};
    next_r.drv_oe_n = !master_in;
    // prescaler then rate divider
    if (half_tick) begin
      next_r.pre_cnt = 7'h00;
      next_r.rate_cnt = 8'h00;
    end else if (pre_wrap) begin
      next_r.pre_cnt = 7'h00;
      next_r.rate_cnt = r.rate_cnt + 8'h01;
    end else begin
      next_r.pre_cnt = r.pre_cnt + 7'h01;
    end
    unique case (r.st)
      SSP_IDLE: begin
        // idle levels follow configuration
        next_r.sclk = idle_now;
        next_r.fss = format_in != SSP_FMT_PULSE;
        next_r.sout = 1'b0;
        next_r.sout_oe_n = !master_in || (format_in == SSP_FMT_PULSE);
        next_r.edge_cnt = 6'h00;
        if (enable_in && master_in) begin
          if (tx_if.count != 4'h0 && half_tick) begin
            start = 1'b1;
            next_r.st = SSP_START;
          end
        end else if (enable_in) begin
          if (format_in != SSP_FMT_PULSE && !r.fss_s[1] && r.fss_s[2]) begin
            start = 1'b1;
            next_r.st = SSP_XFER;
          end else if (format_in == SSP_FMT_PULSE && r.fss_s[1] &&
            r.sclk_s[1] && !r.sclk_s[2]) begin
            start = 1'b1;
            next_r.st = SSP_XFER;
          end
        end
      end
      SSP_START: begin
        // half period of set-up before the first edge
        if (half_tick) begin
          next_r.st = SSP_XFER;
        end
      end
      SSP_XFER: begin
        ev = master_in ? half_tick : s_edge;
        if (!master_in && r.fmt != SSP_FMT_PULSE && r.fss_s[1]) begin
          ev = 1'b0;
          next_r.st = SSP_IDLE;
        end
      end
      SSP_TAIL: begin
        // master holds frame one period after last edge, slave returns to idle at once
        if (!master_in) begin
          next_r.st = SSP_IDLE;
        end else if (half_tick) begin
          next_r.edge_cnt = r.edge_cnt + 6'h01;
          if (r.edge_cnt == SSP_TAIL_HALF - 6'h01) begin
            next_r.st = SSP_IDLE;
          end
        end
      end
    endcase
    // frame load from transmit fifo
    if (start) begin
      tx_if.pop = tx_if.count != 4'h0;
      next_r.fmt = format_in;
      next_r.capf = (format_in == SSP_FMT_CMD) ||
        (format_in == SSP_FMT_SPI && !clock_phase_in);
      next_r.skip = (format_in == SSP_FMT_PULSE) ? SSP_PULSE_SKIP :
        (format_in == SSP_FMT_CMD) ? SSP_CMD_SKIP : 5'h00;
      next_r.slots = nbits + next_r.skip;
      next_r.tx_sh = load_shift(format_in, nbits,
        (tx_if.count != 4'h0) ? tx_if.head : 16'h0000);
      next_r.rx_sh = 16'h0000;
      next_r.sout_oe_n = 1'b0;
      next_r.edge_cnt = (!master_in && format_in == SSP_FMT_PULSE) ?
        6'h01 : 6'h00;
      if (master_in && format_in != SSP_FMT_PULSE) begin
        next_r.fss = 1'b0;
      end
      if (next_r.capf) begin
        next_r.sout = next_r.tx_sh[24];
        next_r.tx_sh = {next_r.tx_sh[23:0], 1'b0};
      end
    end
    // one serial clock edge
    if (ev) begin
      cap = r.edge_cnt[0] ^ r.capf;
      if (master_in) begin
        next_r.sclk = !r.sclk;
      end
      if (cap && r.edge_cnt[5:1] >= {1'b0, r.skip}) begin
        next_r.rx_sh = {r.rx_sh[14:0], in_bit};
      end
      if (!cap && !(r.capf && r.edge_cnt[5:1] == {1'b0, r.slots} - 6'h01))
      begin
        next_r.sout = r.tx_sh[24];
        next_r.tx_sh = {r.tx_sh[23:0], 1'b0};
      end
      if (master_in && r.fmt == SSP_FMT_PULSE) begin
        if (r.edge_cnt == 6'h00) begin
          next_r.fss = 1'b1;
        end else if (r.edge_cnt == 6'h02) begin
          next_r.fss = 1'b0;
        end
      end
      if (r.edge_cnt == {r.slots, 1'b0} - 6'h01) begin
        fin = 1'b1;
        next_r.st = SSP_TAIL;
        next_r.edge_cnt = 6'h00;
      end else begin
        next_r.edge_cnt = r.edge_cnt + 6'h01;
      end
    end
    // end of tail restores idle pins
    if (r.st == SSP_TAIL && next_r.st == SSP_IDLE) begin
      next_r.fss = r.fmt != SSP_FMT_PULSE;
      next_r.sout_oe_n = !master_in || (r.fmt == SSP_FMT_PULSE);
    end
    if (!enable_in) begin
      next_r.st = SSP_IDLE;
    end
    // receive word or overrun
    if (fin && rx_if.count != SSP_FULL) begin
      rx_if.push = 1'b1;
    end
    next_r.ovr = (r.ovr && !overrun_clear_in) ||
      (fin && rx_if.count == SSP_FULL);
    rx_if.push_data = next_r.rx_sh;
    // user side of both fifos
    next_r.tx_ready = (tx_if.count + {3'h0, tx_if.push} -
      {3'h0, tx_if.pop}) < SSP_FULL;
    if (rx_if.pop) begin
      next_r.rx_valid = 1'b0;
    end else if (!r.rx_valid && rx_if.count != 4'h0) begin
      next_r.rx_valid = 1'b1;
      next_r.rx_data = rx_if.head;
    end
    // receive timeout counter
    if (r.st != SSP_IDLE || rx_if.pop || rx_if.count == 4'h0) begin
      next_r.idle_cnt = 7'h00;
    end else if (half_tick && r.idle_cnt != SSP_TIMEOUT_HALF) begin
      next_r.idle_cnt = r.idle_cnt + 7'h01;
    end
    // status and request
    next_r.raw[SSP_IRQ_TX] = tx_if.count <= SSP_TX_SERVICE;
    next_r.raw[SSP_IRQ_RX] = rx_if.count >= SSP_RX_SERVICE;
    next_r.raw[SSP_IRQ_TMO] = (rx_if.count != 4'h0) &&
      (r.idle_cnt == SSP_TIMEOUT_HALF);
    next_r.raw[SSP_IRQ_OVR] = next_r.ovr;
    next_r.mis = next_r.raw & interrupt_mask_in;
    next_r.irq = |next_r.mis;
    next_r.busy = next_r.st != SSP_IDLE;
  end

  // state register
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the state register
  assign tx_ready_out = r.tx_ready;
  assign rx_data_out = r.rx_data;
  assign rx_valid_out = r.rx_valid;
  assign raw_interrupt_status_out = r.raw;
  assign masked_interrupt_status_out = r.mis;
  assign irq_out = r.irq;
  assign busy_out = r.busy;
  assign serial_clock_pin_out = r.sclk;
  assign serial_clock_pin_oe_n_out = r.drv_oe_n;
  assign frame_select_pin_out = r.fss;
  assign frame_select_pin_oe_n_out = r.drv_oe_n;
  assign serial_out_pin_out = r.sout;
  assign serial_out_pin_oe_n_out = r.sout_oe_n;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  irq_combine_a: assert property (irq_out == |masked_interrupt_status_out)
    else $error("request not OR of masked");
  mask_gate_a: assert property (!$past(sys_rst_in) |->
    masked_interrupt_status_out ==
    (raw_interrupt_status_out & $past(interrupt_mask_in)))
    else $error("masked status wrong");
  clock_idle_a: assert property (r.st == SSP_IDLE &&
    $past(r.st) == SSP_IDLE && $past(master_in) |->
    serial_clock_pin_out == $past(idle_now))
    else $error("idle clock level wrong");
  pulse_idle_a: assert property (r.st == SSP_IDLE &&
    $past(r.st) == SSP_IDLE && $past(master_in) &&
    $past(format_in) == SSP_FMT_PULSE |-> serial_out_pin_oe_n_out &&
    !frame_select_pin_out && !serial_clock_pin_out)
    else $error("pulse idle pins wrong");
  frame_low_a: assert property (master_in && r.st == SSP_XFER &&
    r.fmt != SSP_FMT_PULSE |-> !frame_select_pin_out)
    else $error("frame not low in frame");
  pulse_rise_a: assert property (master_in && r.st == SSP_XFER &&
    $rose(frame_select_pin_out) |-> $rose(serial_clock_pin_out))
    else $error("frame pulse off clock rise");
  overrun_flag_a: assert property (fin && rx_if.count == SSP_FULL |->
    !rx_if.push ##1 raw_interrupt_status_out[SSP_IRQ_OVR])
    else $error("overrun not flagged");
  tick_space_a: assert property (half_tick && (psc_half != 7'h01 ||
    serial_clock_rate_in != 8'h00) |=> !half_tick)
    else $error("divider too fast");
  loop_feed_a: assert property (ev && cap && loopback_in &&
    r.edge_cnt[5:1] >= {1'b0, r.skip} |=> r.rx_sh[0] == $past(r.sout))
    else $error("loopback bit lost");

  spi_frame_c: cover property (fin && master_in && r.fmt == SSP_FMT_SPI);
  pulse_frame_c: cover property (fin && r.fmt == SSP_FMT_PULSE);
  cmd_frame_c: cover property (fin && r.fmt == SSP_FMT_CMD);
  overrun_c: cover property (fin && rx_if.count == SSP_FULL);
endmodule

// ---- ssp_spi_slave_model.sv ----
// ssp_spi_slave_model.sv: behavioural spi slave facing the port core.
// assumes: pins sampled on the system clock, master clock well below it.
`timescale 1ns/1ps
module ssp_spi_slave_model (
  input wire logic clk_in,
  input wire logic sclk_in,
  input wire logic fss_n_in,
  input wire logic mosi_in,
  input wire logic cpol_in,
  input wire logic cpha_in,
  input wire logic [3:0] size_in,
  output logic miso_out,
  output logic [15:0] got_out
);
  logic sclk_q = 1'b0; // last clock level
  logic fss_q = 1'b1; // last select level
  logic [15:0] resp = 16'h0000; // word being answered
  int idx = 0; // next response bit
  int n; // bits per frame
  logic lead; // edge leaving the idle level
  initial miso_out = 1'b0;
  initial got_out = 16'h0000;
  assign n = (size_in < 4'h3) ? 4 : size_in + 1;
  assign lead = (sclk_q == cpol_in);
  // echo the word captured in the previous frame, msb first
  always @(posedge clk_in) begin
    sclk_q <= sclk_in;
    fss_q <= fss_n_in;
    if (fss_n_in) begin
      miso_out <= ~miso_out; // deselected: no stale level on the line
    end else if (fss_q) begin
      resp <= got_out;
      if (!cpha_in) miso_out <= got_out[n - 1];
      idx <= cpha_in ? n - 1 : n - 2;
    end else if (sclk_in != sclk_q) begin
      if (lead ^ cpha_in) begin
        got_out <= {got_out[14:0], mosi_in}; // capture edge
      end else if (idx >= 0) begin
        miso_out <= resp[idx]; // launch edge
        idx <= idx - 1;
      end
    end
  end
endmodule

// ---- tb.sv ----
// tb.sv: self-checking bench of the serial port core as master in all three formats and as spi slave.
// assumes: package, fifo, core and slave model compiled first.
`timescale 1ns/1ps
module tb import ssp_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, mst = 1'b1, lpb = 1'b0;
  logic cpol = 1'b0, cpha = 1'b0, ocl = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [1:0] fmt = SSP_FMT_SPI; // frame format
  logic [3:0] size = 4'h7, imask = 4'h0; // bits-1, interrupt mask
  logic [7:0] pre = 8'h04, rate = 8'h01; // half period 4 cycles
  logic [15:0] wdata = 16'h0000; // word to push
  logic [15:0] wq [9]; // words of the fill burst
  logic [31:0] hist = 32'h0; // bits the slave has captured so far
  wire logic tx_rdy, rx_vld, irq, busy, sclk, sclk_oe_n, fss, fss_oe_n;
  wire logic sout, sout_oe_n, miso;
  logic s_clk = 1'b0, s_fss = 1'b1, s_din = 1'b0; // bench as spi master
  wire logic sclk_pin = mst ? sclk : s_clk; // clock pin seen by the port
  wire logic fss_pin = mst ? fss : s_fss; // frame pin seen by the port
  wire logic sin_pin = mst ? miso : s_din; // data pin seen by the port
  wire logic [15:0] rx_data, got;
  wire logic [3:0] raw, msk;
  int fails = 0, samples_checked = 0, seed = 32'h1e4f;
  int gap = 0, since = 0, bad = 0, fhi = 0;
  logic sclk_q = 1'b0;
  always #2.5 clk = ~clk;
  ssp_top dut_u (.ref_clk_in(clk), .sys_rst_in(rst), .enable_in(en),
    .master_in(mst), .format_in(fmt), .clock_polarity_in(cpol),
    .clock_phase_in(cpha), .loopback_in(lpb), .data_size_in(size),
    .clock_prescale_divisor_in(pre), .serial_clock_rate_in(rate),
    .interrupt_mask_in(imask), .overrun_clear_in(ocl), .tx_wr_in(wr),
    .tx_data_in(wdata), .tx_ready_out(tx_rdy), .rx_rd_in(rd),
    .rx_data_out(rx_data), .rx_valid_out(rx_vld),
    .raw_interrupt_status_out(raw), .masked_interrupt_status_out(msk),
    .irq_out(irq), .busy_out(busy), .serial_clock_pin_in(sclk_pin),
    .serial_clock_pin_out(sclk), .serial_clock_pin_oe_n_out(sclk_oe_n),
    .frame_select_pin_in(fss_pin), .frame_select_pin_out(fss),
    .frame_select_pin_oe_n_out(fss_oe_n), .serial_out_pin_out(sout),
    .serial_out_pin_oe_n_out(sout_oe_n), .serial_in_pin_in(sin_pin));
  ssp_spi_slave_model slave_u (.clk_in(clk), .sclk_in(sclk),
    .fss_n_in(fss), .mosi_in(sout), .cpol_in(cpol), .cpha_in(cpha),
    .size_in(size), .miso_out(miso), .got_out(got));
  // edge spacing, frame-select level while clocking, pulse width
  always @(posedge clk) begin
    sclk_q <= sclk;
    since <= (sclk !== sclk_q) ? 1 : since + 1;
    if (sclk !== sclk_q) gap <= since;
    if (sclk !== sclk_q && fmt == SSP_FMT_SPI && busy && fss) bad <= bad + 1;
    if (fmt == SSP_FMT_PULSE && fss === 1'b1) fhi <= fhi + 1;
  end
  function automatic int nbits(input logic [3:0] s);
    return (s < 4'h3) ? 4 : s + 1;
  endfunction
  function automatic logic [15:0] nmask(input logic [3:0] s);
    return 16'hffff >> (16 - nbits(s));
  endfunction
  task automatic close_out;
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // word compare
  task automatic cmp_w(input logic [15:0] got_v, input logic [15:0] exp_v);
    samples_checked++;
    if (got_v !== exp_v) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got_v, exp_v);
    end
  endtask
  // single bit compare
  task automatic cmp_b(input logic got_v, input logic exp_v);
    cmp_w({15'h0, got_v}, {15'h0, exp_v});
  endtask
  task automatic push(input logic [15:0] w);
    @(negedge clk);
    wr = 1'b1;
    wdata = w;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // wait until no frame has run for 40 cycles
  task automatic wait_quiet;
    int q = 0;
    int k = 0;
    while (q < 40) begin
      @(negedge clk);
      q = (busy === 1'b0) ? q + 1 : 0;
      k++;
      if (k > 20000) begin
        fails++;
        close_out();
      end
    end
  endtask
  // read one word, keeping two cycles between reads
  task automatic pop(input logic [15:0] e);
    int k = 0;
    while (rx_vld !== 1'b1) begin
      @(negedge clk);
      k++;
      if (k > 200) begin
        fails++;
        close_out();
      end
    end
    cmp_w(rx_data, e);
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
  endtask
  // one spi frame against the echoing slave
  task automatic frame(input logic [15:0] w);
    logic [15:0] m;
    m = nmask(size);
    push(w);
    wait_quiet();
    cmp_w(got & m, w & m);
    pop(hist[15:0] & m);
    hist = (hist << nbits(size)) | {16'h0, w & m};
  endtask
  // one spi mode 0 frame with the port as slave, clock at sys/16
  task automatic slave_frame(input logic [15:0] tw, input logic [15:0] rw);
    logic [15:0] m;
    logic [15:0] seen;
    m = nmask(size);
    seen = 16'h0000;
    push(tw);
    s_fss = 1'b0;
    for (int b = nbits(size) - 1; b >= 0; b--) begin
      s_din = rw[b];
      repeat (8) @(negedge clk);
      seen = {seen[14:0], sout};
      s_clk = 1'b1;
      repeat (8) @(negedge clk);
      s_clk = 1'b0;
    end
    repeat (8) @(negedge clk);
    s_fss = 1'b1;
    cmp_w(seen & m, tw & m);
    pop(rw & m);
  endtask
  initial begin
    logic [15:0] m;
    repeat (2) @(negedge clk);
    cmp_b(tx_rdy, 1'b0);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    cmp_b(tx_rdy, 1'b1);
    cmp_b(raw[SSP_IRQ_TX], 1'b1);
    cmp_b(fss_oe_n, 1'b0);
    en = 1'b1;
    // every clock mode, random sizes and words
    for (int md = 0; md < 4; md++) begin
      cpol = md[1];
      cpha = md[0];
      size = 4'(3 + {$random(seed)} % 13);
      repeat (20) @(negedge clk);
      cmp_b(sclk, cpol);
      repeat (3) frame(16'($random(seed)));
    end
    size = 4'hf;
    frame(16'h8001);
    size = 4'h3;
    frame(16'h000a);
    // divider: half period of (prescale/2)*(1+rate) cycles
    pre = 8'h06;
    rate = 8'h02;
    frame(16'h0055);
    cmp_w(16'(gap), 16'((pre >> 1) * (rate + 8'h01)));
    pre = 8'h04;
    rate = 8'h01;
    // fill the transmit fifo while disabled, ninth write refused
    en = 1'b0;
    for (int i = 0; i < 9; i++) begin
      wq[i] = 16'($random(seed));
      if (i == 8) repeat (2) @(negedge clk);
      if (i == 8) cmp_b(tx_rdy, 1'b0);
      push(wq[i]);
    end
    imask = 4'h2;
    en = 1'b1;
    wait_quiet();
    cmp_b(raw[SSP_IRQ_RX], 1'b1);
    cmp_w(16'(msk), 16'h0002);
    cmp_b(irq, 1'b1);
    push(16'h1234);
    wait_quiet();
    cmp_b(raw[SSP_IRQ_OVR], 1'b1);
    imask = 4'h0;
    repeat (3) @(negedge clk);
    cmp_b(irq, 1'b0);
    ocl = 1'b1;
    @(negedge clk);
    ocl = 1'b0;
    repeat (3) @(negedge clk);
    cmp_b(raw[SSP_IRQ_OVR], 1'b0);
    for (int i = 0; i < 300 && raw[SSP_IRQ_TMO] !== 1'b1; i++)
      @(negedge clk);
    cmp_b(raw[SSP_IRQ_TMO], 1'b1);
    // eight words kept in order, the overrun word dropped
    m = nmask(size);
    for (int i = 0; i < 8; i++) begin
      pop(hist[15:0] & m);
      hist = (hist << nbits(size)) | {16'h0, wq[i] & m};
    end
    cmp_b(rx_vld, 1'b0);
    // loopback in spi, pulse and command formats
    lpb = 1'b1;
    push(16'h5a3c);
    wait_quiet();
    pop(16'h5a3c & m);
    fmt = SSP_FMT_PULSE;
    repeat (20) @(negedge clk);
    cmp_w({13'h0, sclk, fss, sout_oe_n}, 16'h0001);
    fhi = 0;
    push(16'h00c6);
    wait_quiet();
    pop(16'h00c6 & m);
    cmp_w(16'(fhi), 16'(2 * (pre >> 1) * (rate + 8'h01)));
    fmt = SSP_FMT_CMD;
    push(16'h00e7);
    wait_quiet();
    pop(16'h0000);
    // port as slave, bench drives clock, frame and data in
    fmt = SSP_FMT_SPI;
    lpb = 1'b0;
    cpol = 1'b0;
    cpha = 1'b0;
    size = 4'h7;
    mst = 1'b0;
    repeat (4) @(negedge clk);
    cmp_w({14'h0, sclk_oe_n, fss_oe_n}, 16'h0003);
    repeat (2) slave_frame(16'($random(seed)), 16'($random(seed)));
    cmp_w(16'(bad), 16'h0000);
    close_out();
  end
endmodule
